/* shared/velocity_move_pkg.sv */
package velocity_move_pkg;
	localparam int VEL_WIDTH = 32;
	localparam logic [2:0] DIR_POSITIVE = 3'h1;
	localparam logic [2:0] DIR_NEGATIVE = 3'h3;
	localparam logic [2:0] DIR_CURRENT = 3'h4;
	localparam logic [15:0] ERR_CODE_NONE = 16'h0000;
	// Code reported for illegal inputs; value chosen freely
	localparam logic [15:0] ERR_CODE_PARAM = 16'h0001;
	localparam logic RESET_FLAG = 1'b0;
	localparam int START_CYCLES = 1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_START = 3'b010,
		ST_RUN = 3'b100
	} move_state_e;
endpackage : velocity_move_pkg

/* hw/velocity_move_command.sv */
module velocity_move_command #(
	parameter int VW = velocity_move_pkg::VEL_WIDTH
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic runRequest,
	input wire logic [VW-1:0] targetVelocity,
	input wire logic [VW-1:0] accelLimit,
	input wire logic [VW-1:0] decelLimit,
	input wire logic [VW-1:0] jerkLimit,
	input wire logic [2:0] direction,
	input wire logic takeOver,
	input wire logic execFault,
	input wire logic [15:0] execFaultCode,
	output logic atSpeed,
	output logic busy,
	output logic active,
	output logic aborted_flag,
	output logic errorFlag,
	output logic [15:0] error_code_word,
	output logic signed [VW:0] axisVelocity
);
	velocity_move_pkg::move_state_e state;
	velocity_move_pkg::move_state_e next_state;
	logic runPrev;
	logic [VW-1:0] tgtMag;
	logic [VW-1:0] accel;
	logic [VW-1:0] decel;
	logic [VW-1:0] jerk;
	logic tgtNeg;
	logic [VW-1:0] curRate;

	wire runRise = runRequest & ~runPrev;
	wire runFall = ~runRequest & runPrev;
	wire dirLegal = (direction == velocity_move_pkg::DIR_POSITIVE) ||
		(direction == velocity_move_pkg::DIR_NEGATIVE) ||
		(direction == velocity_move_pkg::DIR_CURRENT);
	wire paramBad = ~dirLegal || (targetVelocity == '0) ||
		(accelLimit == '0) || (decelLimit == '0) || (jerkLimit == '0);
	// Standstill with current direction resolves to positive
	wire dirNegIn = (direction == velocity_move_pkg::DIR_NEGATIVE) ||
		((direction == velocity_move_pkg::DIR_CURRENT) &&
		(axisVelocity < 0));
	wire startOk = runRise & ~paramBad;
	wire startBad = runRise & paramBad;
	wire faultHit = execFault & busy & ~runRise;
	wire abortHit = takeOver & busy & ~runRise & ~faultHit;
	wire stopHit = startBad | faultHit | abortHit;

	// Profile arithmetic, one step per cycle while running
	wire signed [VW:0] tgtSigned = tgtNeg ?
		-$signed({1'b0, tgtMag}) : $signed({1'b0, tgtMag});
	wire signed [VW+1:0] diff = (VW+2)'(tgtSigned) - (VW+2)'(axisVelocity);
	wire [VW+1:0] diffMag = diff[VW+1] ? (VW+2)'(-diff) : diff;
	wire speedUp = (axisVelocity >= 0 && diff > 0) ||
		(axisVelocity <= 0 && diff < 0);
	wire [VW-1:0] rateLimit = speedUp ? accel : decel;
	wire [VW:0] rateRamp = {1'b0, curRate} + {1'b0, jerk};
	wire [VW-1:0] next_rate = (rateRamp > {1'b0, rateLimit}) ?
		rateLimit : rateRamp[VW-1:0];
	wire reached = (diff == '0);
	wire snap = diffMag <= (VW+2)'(next_rate);
	wire signed [VW:0] stepSigned = diff[VW+1] ?
		-$signed({1'b0, next_rate}) : $signed({1'b0, next_rate});
	wire signed [VW:0] next_velocity = snap ? tgtSigned :
		axisVelocity + stepSigned;
	wire running = (state == velocity_move_pkg::ST_RUN);
	// Active follows the state being entered, so it lags busy by one edge
	wire nextRunning = (next_state == velocity_move_pkg::ST_RUN);

	always_comb begin
		next_state = state;
		unique case (state)
			velocity_move_pkg::ST_IDLE: begin
				if (startOk)
					next_state = velocity_move_pkg::ST_START;
			end
			velocity_move_pkg::ST_START: begin
				next_state = velocity_move_pkg::ST_RUN;
			end
			velocity_move_pkg::ST_RUN: begin
				next_state = velocity_move_pkg::ST_RUN;
			end
		endcase
		if (stopHit)
			next_state = velocity_move_pkg::ST_IDLE;
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= velocity_move_pkg::ST_IDLE;
			runPrev <= 1'b0;
		end else begin
			state <= next_state;
			runPrev <= runRequest;
		end
	end

	// Inputs are latched only on the start edge
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tgtMag <= '0;
			accel <= '0;
			decel <= '0;
			jerk <= '0;
			tgtNeg <= 1'b0;
		end else if (startOk) begin
			tgtMag <= targetVelocity;
			accel <= accelLimit;
			decel <= decelLimit;
			jerk <= jerkLimit;
			tgtNeg <= dirNegIn;
		end
	end

	// Jerk ramp restarts from zero at every start and at cruise
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			curRate <= '0;
			axisVelocity <= '0;
		end else if (startOk || !running || reached) begin
			curRate <= '0;
		end else begin
			curRate <= next_rate;
			axisVelocity <= next_velocity;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			busy <= velocity_move_pkg::RESET_FLAG;
			active <= velocity_move_pkg::RESET_FLAG;
			atSpeed <= velocity_move_pkg::RESET_FLAG;
		end else begin
			busy <= (next_state != velocity_move_pkg::ST_IDLE);
			active <= nextRunning;
			// A restart always shows at least one low cycle before at-speed
			atSpeed <= running & reached & ~stopHit & ~runRise;
		end
	end

	// Set wins over the clear while run is low
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			aborted_flag <= velocity_move_pkg::RESET_FLAG;
		end else if (abortHit) begin
			aborted_flag <= 1'b1;
		end else if (!runRequest || runRise) begin
			aborted_flag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			errorFlag <= velocity_move_pkg::RESET_FLAG;
			error_code_word <= velocity_move_pkg::ERR_CODE_NONE;
		end else if (startBad) begin
			errorFlag <= 1'b1;
			error_code_word <= velocity_move_pkg::ERR_CODE_PARAM;
		end else if (faultHit) begin
			errorFlag <= 1'b1;
			error_code_word <= execFaultCode;
		end else if (runFall || startOk) begin
			errorFlag <= 1'b0;
			error_code_word <= velocity_move_pkg::ERR_CODE_NONE;
		end
	end

	chk_busy_then_active: assert property (
		@(posedge core_clk) disable iff (!nrst)
		(state == velocity_move_pkg::ST_IDLE) && startOk
		|=> busy && !active ##1 (active || !busy))
		else $error("active did not follow busy by one cycle");

	chk_speed_with_busy: assert property (
		@(posedge core_clk) disable iff (!nrst)
		atSpeed |-> busy && active && axisVelocity == tgtSigned)
		else $error("at-speed without busy, active or target");

	chk_flag_kills_speed: assert property (
		@(posedge core_clk) disable iff (!nrst)
		$rose(aborted_flag) || $rose(errorFlag) |-> !atSpeed)
		else $error("at-speed stayed high with abort or error");

	chk_retrigger_drop: assert property (
		@(posedge core_clk) disable iff (!nrst)
		atSpeed && startOk |=> !atSpeed)
		else $error("at-speed not dropped on retrigger");

	chk_same_value_blink: assert property (
		@(posedge core_clk) disable iff (!nrst)
		atSpeed && startOk && targetVelocity == tgtMag &&
		dirNegIn == tgtNeg && !takeOver && !execFault
		##1 !takeOver && !execFault && !runRise |=> atSpeed)
		else $error("at-speed not restored after one cycle");

	chk_abort_clears: assert property (
		@(posedge core_clk) disable iff (!nrst)
		abortHit |=> aborted_flag && !busy && !active && !atSpeed)
		else $error("abort did not clear the motion outputs");

	chk_abort_pulse: assert property (
		@(posedge core_clk) disable iff (!nrst)
		abortHit && !runRequest ##1 !takeOver |=> !aborted_flag)
		else $error("abort pulse longer than one cycle");

	chk_abort_hold: assert property (
		@(posedge core_clk) disable iff (!nrst)
		aborted_flag && runRequest && runPrev |=> aborted_flag)
		else $error("aborted flag dropped while run high");

	chk_error_entry: assert property (
		@(posedge core_clk) disable iff (!nrst)
		faultHit |=> errorFlag && !busy && !active &&
		error_code_word == $past(execFaultCode))
		else $error("fault did not load error state");

	chk_error_clear: assert property (
		@(posedge core_clk) disable iff (!nrst)
		errorFlag && runFall && !startBad |=> !errorFlag)
		else $error("error not cleared on run falling edge");

	chk_keep_moving: assert property (
		@(posedge core_clk) disable iff (!nrst)
		active && !runRequest && !takeOver && !execFault |=> active)
		else $error("move stopped after run fell");

	cov_reach_speed: cover property (
		@(posedge core_clk) disable iff (!nrst) $rose(atSpeed));
	cov_abort: cover property (
		@(posedge core_clk) disable iff (!nrst) abortHit);
	cov_param_error: cover property (
		@(posedge core_clk) disable iff (!nrst) startBad);
	cov_retrigger: cover property (
		@(posedge core_clk) disable iff (!nrst) atSpeed && startOk);
endmodule : velocity_move_command

/* tb/servo_axis_model.sv */
module servo_axis_model #(
	parameter logic [15:0] FAULT_CODE = 16'h00a5
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic faultReq,
	output logic execFault,
	output logic [15:0] execFaultCode
);
	timeunit 1ns;
	timeprecision 1ns;
	// Code only means something with the fault; it toggles otherwise
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			execFault <= 1'b0;
			execFaultCode <= 16'h0000;
		end else begin
			execFault <= faultReq;
			execFaultCode <= faultReq ? FAULT_CODE : ~execFaultCode;
		end
	end
endmodule : servo_axis_model

/* tb/velocity_move_command_tb.sv */
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
	mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
	end end
module velocity_move_command_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, nrst = 1'b0, runRequest = 1'b0;
	logic takeOver = 1'b0, faultReq = 1'b0, execFault;
	logic [31:0] targetVelocity = 32'h0;
	logic [2:0] direction = 3'h1;
	logic [15:0] execFaultCode, error_code_word;
	logic atSpeed, busy, active, aborted_flag, errorFlag;
	logic signed [32:0] axisVelocity;
	int mismatches = 0, check_count = 0;
	velocity_move_command DUT (.core_clk(core_clk), .nrst(nrst),
		.runRequest(runRequest), .targetVelocity(targetVelocity),
		.accelLimit(32'h4), .decelLimit(32'h3), .jerkLimit(32'h1),
		.direction(direction), .takeOver(takeOver), .execFault(execFault),
		.execFaultCode(execFaultCode), .atSpeed(atSpeed), .busy(busy),
		.active(active), .aborted_flag(aborted_flag), .errorFlag(errorFlag),
		.error_code_word(error_code_word), .axisVelocity(axisVelocity));
	servo_axis_model AXIS (.core_clk(core_clk), .nrst(nrst),
		.faultReq(faultReq), .execFault(execFault),
		.execFaultCode(execFaultCode));
	initial forever #5 core_clk = ~core_clk;
	task final_report;
		if (mismatches == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	task tick(input int n);
		repeat (n) @(negedge core_clk);
	endtask : tick
	task rise(input logic [31:0] t, input logic [2:0] d);
		targetVelocity = t;
		direction = d;
		runRequest = 1'b1;
		tick(1);
	endtask : rise
	task waitSpeed;
		int i;
		for (i = 0; i < 100 && atSpeed !== 1'b1; i++) tick(1);
		if (atSpeed !== 1'b1) begin
			mismatches++;
			final_report();
		end
	endtask : waitSpeed
	task s_start;
		rise(32'd20, velocity_move_pkg::DIR_CURRENT);
		`CHK({busy, active}, 2'b10)
		tick(1);
		`CHK(active, 1'b1)
		runRequest = 1'b0;
		// Jerk 1 grows the step 1, 2, 3, 4; accel caps the fifth at 4
		tick(5);
		`CHK(axisVelocity, 33'sd14)
		waitSpeed();
		`CHK(axisVelocity, 33'sd20)
		`CHK({busy, active}, 2'b11)
	endtask : s_start
	task s_retrig;
		rise(32'd20, velocity_move_pkg::DIR_CURRENT);
		`CHK(atSpeed, 1'b0)
		tick(1);
		`CHK({atSpeed, busy, active}, 3'b111)
		runRequest = 1'b0;
		tick(1);
		rise(32'd8, velocity_move_pkg::DIR_NEGATIVE);
		`CHK(atSpeed, 1'b0)
		waitSpeed();
		`CHK(axisVelocity, -33'sd8)
		runRequest = 1'b0;
		tick(1);
		rise(32'd8, velocity_move_pkg::DIR_CURRENT);
		waitSpeed();
		`CHK(axisVelocity, -33'sd8)
		`CHK({busy, active}, 2'b11)
	endtask : s_retrig
	task s_fail(input logic bad);
		runRequest = 1'b0;
		tick(1);
		if (bad) begin
			rise(32'd8, 3'h2);
			`CHK(error_code_word, velocity_move_pkg::ERR_CODE_PARAM)
		end else begin
			rise(32'd20, velocity_move_pkg::DIR_POSITIVE);
			waitSpeed();
			faultReq = 1'b1;
			tick(1);
			faultReq = 1'b0;
			tick(1);
			`CHK(error_code_word, 16'h00a5)
		end
		`CHK({errorFlag, atSpeed, busy, active}, 4'b1000)
		tick(2);
		`CHK(errorFlag, 1'b1)
		runRequest = 1'b0;
		tick(1);
		`CHK(errorFlag, 1'b0)
	endtask : s_fail
	task s_abort(input logic runLow);
		rise(32'd20, velocity_move_pkg::DIR_POSITIVE);
		tick(1);
		// Run may fall on the same edge that sees the takeover
		runRequest = !runLow;
		takeOver = 1'b1;
		tick(1);
		takeOver = 1'b0;
		`CHK({aborted_flag, atSpeed, busy, active}, 4'b1000)
		if (!runLow) begin
			tick(2);
			`CHK(aborted_flag, 1'b1)
			runRequest = 1'b0;
		end
		tick(1);
		`CHK(aborted_flag, 1'b0)
	endtask : s_abort
	initial begin
		tick(5);
		nrst = 1'b1;
		tick(1);
		`CHK({atSpeed, busy, active, aborted_flag, errorFlag}, 5'h0)
		`CHK(error_code_word, 16'h0000)
		s_start();
		s_retrig();
		s_fail(1'b1);
		s_fail(1'b0);
		s_abort(1'b0);
		s_abort(1'b1);
		final_report();
	end
endmodule : velocity_move_command_tb
